// *** logic/lcd_port_and_drive_config_regs.vh ***
/*
  register map, field positions and reset values of the lcd port and drive
  configuration block. assumes a 32-bit axi4-lite slave, one word per register.
*/
`ifndef LCD_PORT_AND_DRIVE_CONFIG_REGS_VH
`define LCD_PORT_AND_DRIVE_CONFIG_REGS_VH

// ==========================================================
// register indices and byte addresses
`define LCD_PIN_AND_DUTY_CONTROL_IDX 8'hc0
`define LCD_OPERATION_CONTROL_IDX 8'hc1
`define LCD_PIN_AND_DUTY_CONTROL_ADDR 12'h300
`define LCD_OPERATION_CONTROL_ADDR 12'h304
`define LCD_ADDR_W 12

// ==========================================================
// lcd_pin_and_duty_control fields
`define DUTY_FIELD_HIGH 7
`define DUTY_FIELD_LOW 6
`define BACKPLANE_DUPLICATE_BIT 5
`define EXPANSION_OPTION_BIT 4
`define SEGMENT_GROUP_BIT3 3
`define SEGMENT_GROUP_BIT0 0
`define LCD_PIN_AND_DUTY_CONTROL_RESET 8'h00

// ==========================================================
// lcd_operation_control fields
`define LCD_OP_RESERVED_BIT 7
`define DRIVE_POWER_CONTROL 6
`define DISPLAY_ACTIVATE 5
`define DISPLAY_DATA_CONTROL 4
`define FRAME_CLOCK_BIT3 3
`define FRAME_CLOCK_BIT1 1
`define FRAME_CLOCK_BIT0 0
`define LCD_OPERATION_CONTROL_RESET 8'h80

// ==========================================================
// duty codes and bus answers
`define DUTY_STATIC 2'h0
`define DUTY_HALF 2'h1
`define DUTY_THIRD 2'h2
`define DUTY_QUARTER 2'h3
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// *** logic/lcd_clock_divider.v ***
/*
  free-running divider of the system clock giving one-cycle enable pulses at
  aclk/2 .. aclk/256. assumes sel is stable or that a glitch in one period is
  harmless to the frame timing.
*/
`timescale 1ns/1ns

module lcd_clock_divider #(
  parameter CNT_W = 8
)(
  input wire aclk,
  input wire aresetn,
  input wire run,
  input wire [2:0] sel,
  output reg tick
);

  reg [CNT_W-1:0] cnt;
  wire [CNT_W:0] wide_mask;
  wire [CNT_W-1:0] mask;

  // mask has sel+1 low ones: divide by 2^(sel+1)
  assign wide_mask = ({{(CNT_W-1){1'b0}}, 2'b10} << sel) - {{CNT_W{1'b0}}, 1'b1};
  assign mask = wide_mask[CNT_W-1:0];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt <= {CNT_W{1'b0}};
      tick <= 1'b0;
    end
    else
    begin
      cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      tick <= run & ((cnt & mask) == mask);
    end
  end

endmodule // lcd_clock_divider

// *** logic/lcd_port_and_drive_config.v ***
/*
  lcd port and drive configuration: axi4-lite register slave, segment pin
  function select, backplane routing, frame clock select and data blanking.
  assumes waveforms and ram segment data come from logic on aclk; watch_clk
  is an asynchronous pin, much slower than aclk.
*/
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`include "lcd_port_and_drive_config_regs.vh"

module lcd_port_and_drive_config #(
  parameter SEG_N = 32
)(
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire watch_clk,
  input wire [SEG_N-1:0] ram_seg_data,
  input wire [3:0] com_wave,
  input wire com_nonselect_wave,
  input wire ext_latch_clk,
  input wire ext_shift_clk,
  input wire ext_serial_data,
  input wire ext_phase,
  output reg [SEG_N-1:0] seg_enable,
  output reg [SEG_N-1:0] seg_pin_out,
  output reg expansion_active,
  output reg [3:0] com_enable,
  output reg [3:0] com_out,
  output reg frame_clk_en,
  output reg controller_run,
  output reg drive_power_on
);

  // ==========================================================
  // register bus
  reg [7:0] lcd_pin_and_duty_control;
  reg [7:0] lcd_operation_control;
  reg [`LCD_ADDR_W-1:0] aw_addr;
  reg aw_full;
  reg [7:0] w_byte;
  reg w_lane0;
  reg w_full;
  wire aw_take;
  wire w_take;
  wire do_write;
  wire ar_take;
  wire [`LCD_ADDR_W-1:0] ar_addr;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign do_write = aw_full & w_full & ~s_axi_bvalid;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign ar_addr = s_axi_araddr[`LCD_ADDR_W-1:0];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_RESP_OKAY;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= {`LCD_ADDR_W{1'b0}};
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      lcd_pin_and_duty_control <= `LCD_PIN_AND_DUTY_CONTROL_RESET;
      lcd_operation_control <= `LCD_OPERATION_CONTROL_RESET;
    end
    else
    begin
      if (aw_take)
      begin
        aw_addr <= s_axi_awaddr[`LCD_ADDR_W-1:0];
        aw_full <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_take)
      begin
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
        w_full <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `AXI_RESP_OKAY;
        // only byte lane 0 holds register bits; upper lanes are ignored
        if (aw_addr == `LCD_PIN_AND_DUTY_CONTROL_ADDR)
        begin
          if (w_lane0)
            lcd_pin_and_duty_control <= w_byte;
        end
        else if (aw_addr == `LCD_OPERATION_CONTROL_ADDR)
        begin
          if (w_lane0)
            lcd_operation_control <= {1'b1, w_byte[6:0]};
        end
        else
          s_axi_bresp <= `AXI_RESP_SLVERR;
      end
      if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `AXI_RESP_OKAY;
    end
    else
    begin
      if (ar_take)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `AXI_RESP_OKAY;
        if (ar_addr == `LCD_PIN_AND_DUTY_CONTROL_ADDR)
          s_axi_rdata <= {24'h000000, lcd_pin_and_duty_control};
        else if (ar_addr == `LCD_OPERATION_CONTROL_ADDR)
          s_axi_rdata <= {24'h000000, lcd_operation_control};
        else
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `AXI_RESP_SLVERR;
        end
      end
      if (s_axi_rvalid & s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // field decode
  wire [1:0] duty;
  wire dup;
  wire expand;
  wire [3:0] seg_group;
  wire power_on;
  wire activate;
  wire show_ram;
  wire [3:0] frame_sel;
  wire [2:0] groups_on;

  assign duty = lcd_pin_and_duty_control[`DUTY_FIELD_HIGH:`DUTY_FIELD_LOW];
  assign dup = lcd_pin_and_duty_control[`BACKPLANE_DUPLICATE_BIT];
  assign expand = lcd_pin_and_duty_control[`EXPANSION_OPTION_BIT];
  assign seg_group = lcd_pin_and_duty_control[`SEGMENT_GROUP_BIT3:`SEGMENT_GROUP_BIT0];
  assign power_on = lcd_operation_control[`DRIVE_POWER_CONTROL];
  assign activate = lcd_operation_control[`DISPLAY_ACTIVATE];
  assign show_ram = lcd_operation_control[`DISPLAY_DATA_CONTROL];
  assign frame_sel = lcd_operation_control[`FRAME_CLOCK_BIT3:`FRAME_CLOCK_BIT0];
  // eight-pin groups counted from the top; 0000 and 0001 give none
  assign groups_on = seg_group[3] ? 3'h4 : {1'b0, seg_group[2:1]};

  // ==========================================================
  // frame clock select
  reg watch_meta;
  reg watch_sync;
  reg watch_last;
  reg watch_half;
  wire watch_rise;
  wire sys_tick;
  reg next_frame_tick;

  assign watch_rise = watch_sync & ~watch_last;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      watch_meta <= 1'b0;
      watch_sync <= 1'b0;
      watch_last <= 1'b0;
      watch_half <= 1'b0;
    end
    else
    begin
      watch_meta <= watch_clk;
      watch_sync <= watch_meta;
      watch_last <= watch_sync;
      if (watch_rise)
        watch_half <= ~watch_half;
    end
  end

  lcd_clock_divider #(
    .CNT_W(8)
  ) u_sys_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(activate),
    .sel(frame_sel[2:0]),
    .tick(sys_tick)
  );

  always @*
  begin
    if (frame_sel[3])
      next_frame_tick = sys_tick;
    else if (frame_sel[`FRAME_CLOCK_BIT1])
      next_frame_tick = watch_rise & watch_half;
    else
      next_frame_tick = watch_rise;
  end

  // ==========================================================
  // segment pins
  wire [SEG_N-1:0] next_seg_enable;
  wire [SEG_N-1:0] next_seg_pin_out;
  wire [3:0] ext_sig;

  // top pin first: latch clock, shift clock, serial data, phase
  assign ext_sig = {ext_latch_clk, ext_shift_clk, ext_serial_data, ext_phase};

  genvar gi;
  generate
    for (gi = 0; gi < SEG_N; gi = gi + 1)
    begin : g_seg
      localparam integer GRP_I = gi / 8;
      localparam [2:0] GRP = GRP_I[2:0];
      wire is_ext;
      wire is_seg;
      wire ext_bit;
      assign is_ext = expand & (gi >= SEG_N - 4);
      assign is_seg = ~is_ext & ((GRP + groups_on) >= 3'h4);
      // only the top four pins can carry expansion signals; no index outside ext_sig
      if (gi >= SEG_N - 4)
      begin : g_top
        assign ext_bit = activate & ext_sig[gi + 4 - SEG_N];
      end
      else
      begin : g_low
        assign ext_bit = 1'b0;
      end
      assign next_seg_enable[gi] = is_seg | is_ext;
      // port pins stay low
      assign next_seg_pin_out[gi] = is_ext ? ext_bit :
        (is_seg & activate & show_ram & ram_seg_data[gi]);
    end
  endgenerate

  // ==========================================================
  // backplanes
  reg [3:0] next_com_enable;
  reg [3:0] next_com_wave;

  always @*
  begin
    next_com_enable = 4'hf;
    next_com_wave = com_wave;
    case (duty)
      `DUTY_STATIC:
      begin
        next_com_enable = dup ? 4'hf : 4'h1;
        next_com_wave = {4{com_wave[0]}};
      end
      `DUTY_HALF:
      begin
        next_com_enable = dup ? 4'hf : 4'h3;
        if (dup)
          next_com_wave = {com_wave[1], com_wave[1], com_wave[0], com_wave[0]};
      end
      `DUTY_THIRD:
      begin
        next_com_enable = dup ? 4'hf : 4'h7;
        next_com_wave = {com_nonselect_wave, com_wave[2:0]};
      end
      `DUTY_QUARTER:
      begin
        next_com_enable = 4'hf;
        next_com_wave = com_wave;
      end
      default:
      begin
        next_com_enable = 4'h0;
        next_com_wave = 4'h0;
      end
    endcase
  end

  // ==========================================================
  // output registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      seg_enable <= {SEG_N{1'b0}};
      seg_pin_out <= {SEG_N{1'b0}};
      expansion_active <= 1'b0;
      com_enable <= 4'h0;
      com_out <= 4'h0;
      frame_clk_en <= 1'b0;
      controller_run <= 1'b0;
      drive_power_on <= 1'b0;
    end
    else
    begin
      seg_enable <= next_seg_enable;
      seg_pin_out <= next_seg_pin_out;
      expansion_active <= expand;
      com_enable <= next_com_enable;
      // halted controller drives the enabled backplanes low; com_enable is not gated
      com_out <= activate ? (next_com_wave & next_com_enable) : 4'h0;
      frame_clk_en <= activate & next_frame_tick;
      controller_run <= activate;
      drive_power_on <= power_on;
    end
  end

endmodule // lcd_port_and_drive_config

// *** dv/lcd_cfg_sva.sv ***
/* checker for the lcd port and drive configuration block's lcd-side ports.
   assumes it is bound into lcd_port_and_drive_config on its single aclk. */
`timescale 1ns/1ns
module lcd_cfg_sva #(
  parameter SEG_N = 32
)(
  input wire aclk,
  input wire aresetn,
  input wire ext_latch_clk,
  input wire ext_shift_clk,
  input wire ext_serial_data,
  input wire ext_phase,
  input wire [SEG_N-1:0] seg_enable,
  input wire [SEG_N-1:0] seg_pin_out,
  input wire expansion_active,
  input wire [3:0] com_enable,
  input wire [3:0] com_out,
  input wire frame_clk_en,
  input wire controller_run
);
  // ==========
  // properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_groups;
    !expansion_active |-> seg_enable inside
      {32'h0, 32'hff000000, 32'hffff0000, 32'hffffff00, 32'hffffffff};
  endproperty
  a_groups: assert property (p_groups) else $error("bad pin group");
  property p_port_low;
    (seg_pin_out & ~seg_enable) == 32'h0;
  endproperty
  a_port_low: assert property (p_port_low) else $error("port pin driven");
  property p_exp_top;
    expansion_active |-> seg_enable[31:28] == 4'hf;
  endproperty
  a_exp_top: assert property (p_exp_top) else $error("top pins not lcd");
  property p_exp_sig;
    expansion_active && controller_run |-> seg_pin_out[31:28] ==
      $past({ext_latch_clk, ext_shift_clk, ext_serial_data, ext_phase});
  endproperty
  a_exp_sig: assert property (p_exp_sig) else $error("bad expansion pin");
  property p_com_off;
    (com_out & ~com_enable) == 4'h0;
  endproperty
  a_com_off: assert property (p_com_off) else $error("unused com driven");
  property p_halt;
    !controller_run |-> seg_pin_out == 32'h0 && com_out == 4'h0;
  endproperty
  a_halt: assert property (p_halt) else $error("drive while halted");
  property p_tick_run;
    (!controller_run) [*3] |-> !frame_clk_en;
  endproperty
  a_tick_run: assert property (p_tick_run) else $error("tick while halted");
  property p_tick_pulse;
    frame_clk_en |=> !frame_clk_en;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
endmodule // lcd_cfg_sva

bind lcd_port_and_drive_config lcd_cfg_sva #(.SEG_N(SEG_N)) u_sva (
  .aclk(aclk), .aresetn(aresetn), .ext_latch_clk(ext_latch_clk),
  .ext_shift_clk(ext_shift_clk), .ext_serial_data(ext_serial_data),
  .ext_phase(ext_phase), .seg_enable(seg_enable), .seg_pin_out(seg_pin_out),
  .expansion_active(expansion_active), .com_enable(com_enable), .com_out(com_out),
  .frame_clk_en(frame_clk_en), .controller_run(controller_run)
);

// *** dv/lcd_far_side.sv ***
/* far-side drive source model: backplane phase waves, non-selected wave and
   expansion signals. assumes aclk from the bench; every output moves often. */
`timescale 1ns/1ns
module lcd_far_side (
  input wire aclk,
  output logic [3:0] com_wave,
  output logic com_nonselect_wave,
  output logic [3:0] ext_sig
);
  // ==========
  // pattern source
  logic [8:0] cnt = 9'h0;
  // odd step, so a stuck or swapped output bit shows quickly
  always @(posedge aclk)
    cnt <= cnt + 9'h0b5;
  assign com_wave = cnt[3:0];
  assign com_nonselect_wave = cnt[4];
  assign ext_sig = cnt[8:5];
endmodule // lcd_far_side

// *** dv/tb.sv ***
/* self-checking bench: axi4-lite master tasks, one task per scenario, watchdog.
   assumes the far-side model drives the waves and a free watch clock pin. */
`timescale 1ns/1ns
`include "lcd_port_and_drive_config_regs.vh"
module tb;
  localparam [31:0] A0 = `LCD_PIN_AND_DUTY_CONTROL_ADDR;
  localparam [31:0] A1 = `LCD_OPERATION_CONTROL_ADDR;
  logic aclk = 0, aresetn = 0, watch_clk = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic [31:0] ram = 32'h5a3c96e1, seg_enable, seg_pin_out;
  logic awvalid = 0, wvalid = 0, arvalid = 0, awready, wready, arready, bvalid, rvalid;
  logic [3:0] wstrb = 0, com_wave, ext_sig, com_enable, com_out;
  logic [1:0] bresp, rresp;
  logic nsw, expansion_active, frame_clk_en, controller_run, drive_power_on;
  int failures = 0, num_checks = 0;

  // ==========
  // instances and clocks
  lcd_port_and_drive_config dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .watch_clk(watch_clk), .ram_seg_data(ram), .com_wave(com_wave),
    .com_nonselect_wave(nsw), .ext_latch_clk(ext_sig[3]), .ext_shift_clk(ext_sig[2]),
    .ext_serial_data(ext_sig[1]), .ext_phase(ext_sig[0]), .seg_enable(seg_enable),
    .seg_pin_out(seg_pin_out), .expansion_active(expansion_active),
    .com_enable(com_enable), .com_out(com_out), .frame_clk_en(frame_clk_en),
    .controller_run(controller_run), .drive_power_on(drive_power_on));
  lcd_far_side far (.aclk(aclk), .com_wave(com_wave), .com_nonselect_wave(nsw),
    .ext_sig(ext_sig));
  initial forever #10 aclk = ~aclk;
  // 340 ns period, seventeen aclk periods
  // offset keeps watch_clk edges off the aclk edges
  initial
  begin
    #5;
    forever #170 watch_clk = ~watch_clk;
  end

  // ==========
  // bus and check tasks
  task automatic wr(input logic [31:0] a, d, input logic [3:0] s, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    // no cycle count assumed: the wait ends on bvalid, or at the watchdog if bvalid never comes
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end
    while (!bvalid);
    r = bresp;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
  task automatic chk(input logic [31:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      failures++;
      $display("Error %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask

  // ==========
  // scenarios
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rd(A0, d, r);
    chk(d, 32'h0);
    rd(A1, d, r);
    chk(d, 32'h80);
    #1;
    chk(com_enable, 4'h1);
    chk(seg_enable, 32'h0);
    rd(32'h308, d, r);
    chk(r, `AXI_RESP_SLVERR);
    $display("t_reset done");
  endtask
  task automatic t_bus;
    logic [31:0] d;
    logic [1:0] r;
    wr(A1, 32'h40, 4'h1, r);
    settle;
    chk(drive_power_on, 1'b1);
    chk(controller_run, 1'b0);
    chk(seg_pin_out | com_out, 32'h0);
    wr(A1, 32'h0, 4'h0, r);
    chk(r, `AXI_RESP_OKAY);
    wr(32'h310, 32'h0, 4'h1, r);
    chk(r, `AXI_RESP_SLVERR);
    rd(A1, d, r);
    chk(d, 32'hc0);
    wr(A1, 32'h0, 4'h1, r);
    rd(A1, d, r);
    chk(d, 32'h80);
    settle;
    chk(drive_power_on, 1'b0);
    $display("t_bus done");
  endtask
  task automatic t_groups;
    logic [31:0] e;
    logic [1:0] r;
    wr(A1, 32'h30, 4'h1, r);
    // expansion stays off while a group code is set
    for (int c = 0; c < 16; c++)
    begin
      wr(A0, c, 4'h1, r);
      e = c[3] ? 32'hffffffff : ~(32'hffffffff >> (8 * c[2:1]));
      settle;
      chk(seg_enable, e);
      chk(seg_pin_out, e & ram);
    end
    wr(A1, 32'h20, 4'h1, r);
    settle;
    chk(controller_run, 1'b1);
    chk(seg_pin_out, 32'h0);
    $display("t_groups done");
  endtask
  task automatic t_duty;
    logic [3:0] w, o, en;
    logic n;
    logic [1:0] r;
    for (int k = 0; k < 8; k++)
    begin
      wr(A0, {24'h0, k[2:1], k[0], 5'h0}, 4'h1, r);
      @(posedge aclk);
      w = com_wave;
      n = nsw;
      #1;
      case (k)
        0: o = {3'h0, w[0]};
        1: o = {4{w[0]}};
        2: o = {2'h0, w[1:0]};
        3: o = {w[1], w[1], w[0], w[0]};
        4: o = {1'h0, w[2:0]};
        5: o = {n, w[2:0]};
        default: o = w;
      endcase
      en = (k[0] || k > 5) ? 4'hf : (4'h2 << k[2:1]) - 4'h1;
      chk(com_enable, en);
      chk(com_out, o);
    end
    $display("t_duty done");
  endtask
  task automatic t_exp;
    logic [3:0] x;
    logic [1:0] r;
    wr(A0, 32'h10, 4'h1, r);
    settle;
    chk(seg_enable, 32'hf0000000);
    chk(expansion_active, 1'b1);
    @(posedge aclk);
    x = ext_sig;
    #1;
    chk(seg_pin_out[31:28], x);
    $display("t_exp done");
  endtask
  task automatic t_clock;
    int cnt, e;
    logic [1:0] r;
    for (int k = 0; k < 10; k++)
    begin
      wr(A1, k < 8 ? 32'h28 + k : 32'h20 + 2 * (k - 8), 4'h1, r);
      repeat (4) @(posedge aclk);
      cnt = 0;
      repeat (512)
      begin
        @(posedge aclk);
        cnt += frame_clk_en;
      end
      e = k < 8 ? 256 >> k : 30 / (k - 7);
      chk(cnt >= e && cnt <= e + (k < 8 ? 0 : 1), 1);
    end
    $display("t_clock done");
  endtask

  // ==========
  // sequence, watchdog, verdict
  task automatic wrap_up;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    t_reset;
    t_bus;
    t_groups;
    t_duty;
    t_exp;
    t_clock;
    wrap_up;
  end
  // about 5500 cycles expected; cut at 20000
  initial
  begin
    #400000;
    failures++;
    wrap_up;
  end
endmodule // tb
